// ==== design/pda_pkg.sv ====
// shared constants for the pipelined converter digital core
package pda_pkg;
	localparam int NUM_STAGES = 9;
	localparam int OUT_W = 10;
	localparam int RES_W = 12;
	localparam int FIFO_DEPTH = 4;
	localparam int TOP_BIT_POS = 9;
	localparam int BOTTOM_BIT_POS = 0;
	localparam int LATENCY_HALF_CYCLES = 13;
	localparam int CONV_DUTY_PCT = 50;
	localparam int SUM_W = 11;
	localparam logic [10:0] MAX_CODE = 11'h3ff;
	localparam logic [9:0] FULL_SCALE_CODE = 10'h3ff;
	localparam logic RESET_LOW = 1'h0;
endpackage

// ==== design/pda_stage.sv ====
// one 2-bit quantizer stage with reconstruction and residue doubling
`timescale 1ns/100ps
module pda_stage #(
	parameter int RES_W = 12,
	parameter bit LAST = 1'b0
) (
	input wire logic [RES_W-1:0] resid_in,
	output logic [1:0] code,
	output logic [RES_W-1:0] resid_out
);
	localparam logic [RES_W-1:0] THR_LO = RES_W'(3 << (RES_W - 3));
	localparam logic [RES_W-1:0] THR_HI = RES_W'(5 << (RES_W - 3));
	localparam logic [RES_W:0] HALF_FS = (RES_W + 1)'(1 << (RES_W - 1));
	localparam logic [RES_W:0] FULL_FS = (RES_W + 1)'(1 << RES_W);

	logic [RES_W:0] twice;
	logic [RES_W:0] sub;
	logic [RES_W:0] diff;

	if (RES_W < 6) begin : g_bad_width
		$error("pda_stage: RES_W too small");
	end

	// thresholds at 3/8 and 5/8 leave half a range of overlap for the correction stage
	always_comb begin
		twice = {resid_in, 1'b0};
		if (LAST) begin
			code = resid_in[RES_W-1 -: 2];
		end else if (resid_in < THR_LO) begin
			code = 2'h0;
		end else if (resid_in < THR_HI) begin
			code = 2'h1;
		end else begin
			code = 2'h2;
		end
		case (code)
			2'h1: sub = HALF_FS;
			2'h2: sub = FULL_FS;
			default: sub = '0;
		endcase
		diff = twice - sub;
		resid_out = diff[RES_W-1:0];
	end
endmodule

// ==== design/pda_fifo.sv ====
// small synchronous fifo with valid/ready on both sides
`timescale 1ns/100ps
module pda_fifo #(
	parameter int WIDTH = 10,
	parameter int DEPTH = 4
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);

	logic [WIDTH-1:0] mem_reg [0:DEPTH-1];
	logic [AW-1:0] wr_reg, wr_next, rd_reg, rd_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic push, pop;

	if (DEPTH < 2 || (1 << AW) != DEPTH) begin : g_bad_depth
		$error("pda_fifo: DEPTH must be a power of two, at least 2");
	end

	assign in_ready = cnt_reg != (AW + 1)'(DEPTH);
	assign out_valid = cnt_reg != '0;
	assign out_data = mem_reg[rd_reg];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_comb begin
		wr_next = push ? wr_reg + 1'b1 : wr_reg;
		rd_next = pop ? rd_reg + 1'b1 : rd_reg;
		cnt_next = cnt_reg;
		if (push && !pop) begin
			cnt_next = cnt_reg + 1'b1;
		end else if (pop && !push) begin
			cnt_next = cnt_reg - 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			wr_reg <= '0;
			rd_reg <= '0;
			cnt_reg <= '0;
		end else begin
			wr_reg <= wr_next;
			rd_reg <= rd_next;
			cnt_reg <= cnt_next;
		end
	end

	// storage needs no reset; out_valid guards every read
	always_ff @(posedge ref_clk) begin
		if (push) begin
			mem_reg[wr_reg] <= in_data;
		end
	end
endmodule

// ==== design/pda_core.sv ====
// digital core of a 10-bit pipelined sampling converter
// Contract
// - two non-overlapping phases are derived from the convert clock, one tracking and one holding.
// - the conversion pipeline has nine stages in series.
// - each stage resolves a two-bit code and hands the matching residue to the next stage.
// - each stage converts on an edge of a sub-clock at the convert clock rate.
// - each stage code travels down its own delay line so that all codes of one sample line up.
// - an error-correction adder combines the aligned codes using their redundant bits.
// - the corrected word is monotonic and reaches every 10-bit code with none skipped.
// - each sample leaves as a 10-bit parallel word, most significant bit on the first line.
// - output coding is selectable between straight offset binary and two's complement.
// - a high coding-select input inverts the top output bit, a low one leaves the straight code.
// - a high output-float input releases all data lines, a low one drives them.
// - a valid word appears six and a half convert cycles after the edge that started its sample.
// - full-scale positive input gives all ones in offset binary, top bit inverted in two's complement.
`timescale 1ns/100ps
module pda_core #(
	parameter int RES_W = pda_pkg::RES_W,
	parameter int FIFO_DEPTH = pda_pkg::FIFO_DEPTH
) (
	input wire logic ref_clk,
	input wire logic rst,
	input wire logic conv_clk,
	input wire logic [RES_W-1:0] ain_sample,
	input wire logic top_bit_invert,
	input wire logic out_float,
	output logic track_phase,
	output logic hold_phase,
	output logic [pda_pkg::OUT_W-1:0] data_bits,
	output logic data_oe,
	output logic data_strobe,
	output logic overrun
);
	localparam int NS = pda_pkg::NUM_STAGES;
	localparam int OW = pda_pkg::OUT_W;
	localparam int SW = pda_pkg::SUM_W;
	localparam logic [3:0] LAT_EDGES = 4'(pda_pkg::LATENCY_HALF_CYCLES + 1);

	// convert clock sampling and phase generation
	logic conv_q_reg, conv_q_next, conv_p_reg, conv_p_next;
	logic track_reg, track_next, hold_reg, hold_next;
	logic rise_w, fall_w, edge_w;

	// pipeline state: index 0 is the track/hold, 1..NS the quantizer stages
	logic [RES_W-1:0] resid_reg [0:NS];
	logic [RES_W-1:0] resid_next [0:NS];
	logic [2*NS-1:0] codes_reg [0:NS];
	logic [2*NS-1:0] codes_next [0:NS];
	logic [NS:0] vld_reg, vld_next;
	logic [1:0] st_code_w [1:NS];
	logic [RES_W-1:0] st_res_w [1:NS];

	// correction and output path
	logic [SW-1:0] corr_sum_w;
	logic [OW-1:0] corr_reg, corr_next, hold_word_reg, hold_word_next;
	logic corr_vld_reg, corr_vld_next, hold_vld_reg, hold_vld_next;
	logic [OW-1:0] data_reg, data_next;
	logic oe_reg, oe_next, strobe_reg, strobe_next, ovr_reg, ovr_next;
	logic fifo_in_valid, fifo_in_ready, fifo_out_valid, fifo_out_ready;
	logic [OW-1:0] fifo_out_data;

	// checker state: strobes since the last rising convert edge, sub-clock edges since the first sample
	logic [1:0] words_reg, words_next;
	logic pushed_reg, pushed_next;
	logic [3:0] edges_reg, edges_next;

	if (pda_pkg::LATENCY_HALF_CYCLES + 1 >= 15) begin : g_bad_lat
		$error("pda_core: latency does not fit the edge counter");
	end

	if (RES_W < OW + 2) begin : g_bad_res
		$error("pda_core: RES_W must exceed OUT_W by two bits");
	end

	// conv_clk is synchronous to ref_clk, so its first flop may be read directly
	assign rise_w = conv_q_reg && !conv_p_reg;
	assign fall_w = !conv_q_reg && conv_p_reg;
	assign edge_w = rise_w || fall_w;

	always_comb begin
		conv_q_next = conv_clk;
		conv_p_next = conv_q_reg;
		// one dead ref_clk cycle at every transition keeps the phases apart
		track_next = !conv_q_reg && !conv_p_reg;
		hold_next = conv_q_reg && conv_p_reg;
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			conv_q_reg <= pda_pkg::RESET_LOW;
			conv_p_reg <= pda_pkg::RESET_LOW;
			track_reg <= pda_pkg::RESET_LOW;
			hold_reg <= pda_pkg::RESET_LOW;
		end else begin
			conv_q_reg <= conv_q_next;
			conv_p_reg <= conv_p_next;
			track_reg <= track_next;
			hold_reg <= hold_next;
		end
	end

	// nine quantizer stages in series
	for (genvar k = 1; k <= NS; k++) begin : g_stage
		pda_stage #(
			.RES_W(RES_W),
			.LAST(k == NS)
		) u_stage (
			.resid_in(resid_reg[k-1]),
			.code(st_code_w[k]),
			.resid_out(st_res_w[k])
		);
	end

	always_comb begin
		for (int k = 0; k <= NS; k++) begin
			resid_next[k] = resid_reg[k];
			codes_next[k] = codes_reg[k];
		end
		vld_next = vld_reg;
		// the rising convert edge ends tracking and starts the conversion
		if (rise_w) begin
			resid_next[0] = ain_sample;
			vld_next[0] = 1'b1;
		end
		for (int k = 1; k <= NS; k++) begin
			// odd stages convert on falling edges, even ones on rising: two sub-clock edges per cycle
			if ((k % 2 == 1) ? fall_w : rise_w) begin
				resid_next[k] = st_res_w[k];
				codes_next[k] = codes_reg[k-1];
				codes_next[k][2*(k-1) +: 2] = st_code_w[k];
				vld_next[k] = vld_reg[k-1];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			for (int k = 0; k <= NS; k++) begin
				resid_reg[k] <= '0;
				codes_reg[k] <= '0;
			end
			vld_reg <= '0;
		end else begin
			for (int k = 0; k <= NS; k++) begin
				resid_reg[k] <= resid_next[k];
				codes_reg[k] <= codes_next[k];
			end
			vld_reg <= vld_next;
		end
	end

	// overlapping weights: stage k counts 2^(NS-k); the third code value spills into the next bit
	always_comb begin
		corr_sum_w = '0;
		for (int k = 1; k <= NS; k++) begin
			corr_sum_w = corr_sum_w + (SW'(codes_reg[NS][2*(k-1) +: 2]) << (NS - k));
		end
	end

	always_comb begin
		corr_next = corr_reg;
		corr_vld_next = corr_vld_reg;
		hold_word_next = hold_word_reg;
		hold_vld_next = hold_vld_reg;
		if (rise_w) begin
			corr_next = corr_sum_w[OW-1:0];
			corr_vld_next = vld_reg[NS];
		end
		if (fall_w) begin
			hold_word_next = corr_reg;
			hold_vld_next = corr_vld_reg;
		end
	end

	// the fifo absorbs ref_clk jitter between push on the rising edge and pop on the falling one
	assign fifo_in_valid = rise_w && hold_vld_reg;
	assign fifo_out_ready = fall_w;

	pda_fifo #(
		.WIDTH(OW),
		.DEPTH(FIFO_DEPTH)
	) u_fifo (
		.ref_clk(ref_clk),
		.rst(rst),
		.in_valid(fifo_in_valid),
		.in_ready(fifo_in_ready),
		.in_data(hold_word_reg),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_out_ready),
		.out_data(fifo_out_data)
	);

	always_comb begin
		data_next = data_reg;
		strobe_next = 1'b0;
		oe_next = !out_float;
		// a word refused by a full fifo cannot be stalled at the source, so it is flagged
		ovr_next = ovr_reg || (fifo_in_valid && !fifo_in_ready);
		if (fifo_out_valid && fifo_out_ready) begin
			data_next = fifo_out_data;
			// only the top line flips between the two codings
			data_next[pda_pkg::TOP_BIT_POS] = fifo_out_data[pda_pkg::TOP_BIT_POS] ^ top_bit_invert;
			strobe_next = 1'b1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			corr_reg <= '0;
			corr_vld_reg <= 1'b0;
			hold_word_reg <= '0;
			hold_vld_reg <= 1'b0;
			data_reg <= '0;
			oe_reg <= 1'b0;
			strobe_reg <= 1'b0;
			ovr_reg <= 1'b0;
		end else begin
			corr_reg <= corr_next;
			corr_vld_reg <= corr_vld_next;
			hold_word_reg <= hold_word_next;
			hold_vld_reg <= hold_vld_next;
			data_reg <= data_next;
			oe_reg <= oe_next;
			strobe_reg <= strobe_next;
			ovr_reg <= ovr_next;
		end
	end

	assign track_phase = track_reg;
	assign hold_phase = hold_reg;
	assign data_bits = data_reg;
	assign data_oe = oe_reg;
	assign data_strobe = strobe_reg;
	assign overrun = ovr_reg;

	always_comb begin
		words_next = words_reg;
		pushed_next = pushed_reg;
		edges_next = edges_reg;
		if (rise_w) begin
			words_next = 2'h0;
			pushed_next = fifo_in_valid;
		end else if (strobe_reg && words_reg != 2'h3) begin
			words_next = words_reg + 2'h1;
		end
		// counting starts at the first sampling edge and saturates at 15, one edge past the 14-edge latency
		if (edge_w && (rise_w || edges_reg != 4'h0) && edges_reg != 4'hf) begin
			edges_next = edges_reg + 4'h1;
		end
	end

	always_ff @(posedge ref_clk) begin
		if (rst) begin
			words_reg <= 2'h0;
			pushed_reg <= 1'b0;
			edges_reg <= 4'h0;
		end else begin
			words_reg <= words_next;
			pushed_reg <= pushed_next;
			edges_reg <= edges_next;
		end
	end

	default clocking cb @(posedge ref_clk);
	endclocking
	default disable iff (rst);

	phases_apart_a: assert property (!(track_reg && hold_reg))
		else $error("track and hold phases overlap");
	phase_gap_a: assert property ($fell(track_reg) |-> !hold_reg ##1 1'b1)
		else $error("hold phase opened without a dead cycle");
	for (genvar k = 1; k < NS; k++) begin : g_chk
		stage_code_a: assert property (vld_reg[k] |-> codes_reg[k][2*(k-1) +: 2] != 2'h3)
			else $error("redundant stage produced code three");
	end
	stage_hold_a: assert property (!fall_w |=> $stable(resid_reg[1]))
		else $error("stage one converted off its sub-clock edge");
	corr_range_a: assert property (corr_sum_w <= pda_pkg::MAX_CODE)
		else $error("corrected sum exceeds full scale");
	strobe_fall_a: assert property (data_strobe |-> $past(fall_w))
		else $error("word left off a falling convert edge");
	pop_word_a: assert property (fall_w && fifo_out_valid |=> data_strobe ##1 !data_strobe)
		else $error("ready word not presented for exactly one cycle");
	top_bit_a: assert property (data_strobe |-> data_bits[pda_pkg::TOP_BIT_POS]
		== ($past(fifo_out_data[pda_pkg::TOP_BIT_POS]) ^ $past(top_bit_invert)))
		else $error("top bit coding wrong");
	float_a: assert property (out_float ##1 out_float |-> !data_oe)
		else $error("data driven while floated");
	hold_follow_a: assert property ($rose(conv_clk) |-> ##3 hold_reg)
		else $error("hold phase did not follow the convert clock");
	track_follow_a: assert property ($fell(conv_clk) |-> ##3 track_reg)
		else $error("track phase did not follow the convert clock");
	even_stage_a: assert property (!rise_w |=> $stable(resid_reg[2]))
		else $error("stage two converted off its sub-clock edge");
	fifo_take_a: assert property (fifo_in_valid |-> fifo_in_ready)
		else $error("corrected word refused by the fifo");
	one_word_a: assert property (rise_w && pushed_reg |-> words_reg == 2'h1)
		else $error("not exactly one word in a convert cycle");
	early_word_a: assert property (data_strobe |-> edges_reg >= LAT_EDGES)
		else $error("word left before the pipeline latency");
	word_latency_a: assert property ($past(fall_w) && edges_reg == LAT_EDGES |-> data_strobe)
		else $error("first word missing at the pipeline latency");
	data_hold_a: assert property (!data_strobe && !$past(rst) |-> $stable(data_bits))
		else $error("data lines changed without a strobe");

	word_out_c: cover property (data_strobe);
	invert_c: cover property (data_strobe && $past(top_bit_invert));
	full_scale_c: cover property (data_strobe && data_bits == pda_pkg::FULL_SCALE_CODE);
	float_c: cover property ($fell(data_oe));
	latency_c: cover property ($past(fall_w) && edges_reg == LAT_EDGES && data_strobe);
endmodule

// ==== dv/pda_capture.sv ====
// capture logic model that latches each output word
`timescale 1ns/100ps
module pda_capture (
	input wire logic ref_clk,
	input wire logic [9:0] data_in,
	input wire logic data_strobe,
	output logic [9:0] word,
	output logic word_valid
);
	logic strobe_d = 1'h0;
	initial word_valid = 1'h0;
	// latch one clock after the strobe so the lines have settled
	always @(posedge ref_clk) begin
		strobe_d <= data_strobe;
		word_valid <= strobe_d;
		if (strobe_d) begin
			word <= data_in;
		end
	end
endmodule

// ==== dv/pda_core_tb_top.sv ====
// self-checking bench for the converter digital core
`timescale 1ns/100ps
module pda_core_tb_top;
	localparam int H = 3;
	logic ref_clk = 1'h0;
	logic rst = 1'h1;
	logic conv_clk = 1'h0;
	logic top_bit_invert = 1'h0;
	logic out_float = 1'h0;
	logic [11:0] ain_sample = 12'h000;
	logic track_phase, hold_phase, data_oe, data_strobe, overrun, cap_valid;
	logic [9:0] data_bits, cap_word;
	wire [9:0] data_wire;
	logic [9:0] exp_q[$];
	logic lat_on = 1'h0;
	int n_mismatch = 0;
	int num_checks = 0;
	int n_words = 0;
	int lat = 0;
	int lat_cnt = 0;

	// released lines float, the pull-downs are off-chip of this model
	assign data_wire = data_oe ? data_bits : {10{1'bz}};

	pda_core uut (.ref_clk(ref_clk), .rst(rst), .conv_clk(conv_clk), .ain_sample(ain_sample),
		.top_bit_invert(top_bit_invert), .out_float(out_float), .track_phase(track_phase),
		.hold_phase(hold_phase), .data_bits(data_bits), .data_oe(data_oe),
		.data_strobe(data_strobe), .overrun(overrun));
	pda_capture cap (.ref_clk(ref_clk), .data_in(data_wire), .data_strobe(data_strobe),
		.word(cap_word), .word_valid(cap_valid));

	initial begin
		forever #2.5 ref_clk = ~ref_clk;
	end

	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp) begin
			n_mismatch++;
			$display("mismatch at %0t: got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic summarize();
		$display("checks %0d mismatches %0d", num_checks, n_mismatch);
		if (n_mismatch == 0 && num_checks > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask

	always @(posedge ref_clk) begin
		if (cap_valid) begin
			n_words++;
			if (exp_q.size() != 0) begin
				check({2'h0, cap_word}, {2'h0, exp_q.pop_front()});
			end else begin
				check(12'hbad, 12'h000);
			end
		end
		if (lat_on) begin
			lat_cnt++;
			if (data_strobe) begin
				lat = lat_cnt;
				lat_on = 1'h0;
			end
		end
	end

	task automatic do_reset(input logic inv);
		rst = 1'h1;
		top_bit_invert = inv;
		conv_clk = 1'h0;
		repeat (8) @(negedge ref_clk);
		rst = 1'h0;
		@(negedge ref_clk);
		check({10'h0, data_strobe, overrun}, 12'h000);
	endtask

	// one half of the convert period; the phases must follow the level by now
	task automatic half();
		repeat (H) @(negedge ref_clk);
		check({10'h0, hold_phase, track_phase}, {10'h0, conv_clk, ~conv_clk});
	endtask

	// even halves give the nominal duty ratio
	task automatic run(input logic inv, input int n);
		logic [11:0] v;
		do_reset(inv);
		n_words = 0;
		exp_q = {};
		lat = 0;
		for (int i = 0; i < n + 8; i++) begin
			v = (i == 0) ? 12'hfff : (i == 1) ? 12'h000 : 12'(i * 331 + 7);
			ain_sample = v;
			conv_clk = 1'h1;
			if (i == 0) begin
				lat_cnt = 0;
				lat_on = 1'h1;
			end
			// one word per sample, floor of input over four, top bit flipped on select
			exp_q.push_back({v[11] ^ inv, v[10:2]});
			half();
			conv_clk = 1'h0;
			half();
		end
		// sampling edge two clocks after the rise, strobe seen three clocks after the falling level
		check({11'h0, lat == pda_pkg::LATENCY_HALF_CYCLES * H + 3}, 12'h001);
		check({11'h0, n_words >= n}, 12'h001);
		check({11'h0, overrun}, 12'h000);
	endtask

	// float toggled only while the convert clock stands still
	task automatic float_test();
		do_reset(1'h0);
		out_float = 1'h1;
		repeat (2) @(negedge ref_clk);
		check({2'h0, data_wire}, {2'h0, {10{1'bz}}});
		out_float = 1'h0;
		repeat (2) @(negedge ref_clk);
		check({11'h0, data_oe}, 12'h001);
	endtask

	initial begin
		run(1'h0, 40);
		float_test();
		run(1'h1, 40);
		summarize();
	end

	initial begin
		repeat (20000) @(posedge ref_clk);
		n_mismatch++;
		summarize();
	end
endmodule
